// file: design/scc_pkg.sv
// package for the system clock control block: register map, fields, resets
// assumes a 32-bit apb bus whose byte address is four times the register index

package scc_pkg;

  // ***********************************************************
  // bus geometry
  // ***********************************************************
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;

  // ***********************************************************
  // register indexes, byte address is index times four
  // ***********************************************************
  localparam logic [15:0] IDX_CTRL = 16'hff10;
  localparam logic [15:0] IDX_FILT = 16'hff11;
  localparam logic [15:0] IDX_RATIO = 16'hff12;
  localparam logic [15:0] IDX_SRC = 16'hff18;
  localparam logic [15:0] IDX_IRQ_STAT = 16'hff19;
  localparam logic [15:0] IDX_IRQ_EN = 16'hff1a;
  localparam logic [15:0] IDX_IRQ_CLR = 16'hff1b;

  // ***********************************************************
  // control and status field positions
  // ***********************************************************
  localparam int CTRL_FAULT_BIT = 7;
  localparam int CTRL_VSEL_LO = 5;
  localparam int CTRL_WDCLR_BIT = 2;
  localparam int CTRL_WDARM_BIT = 1;
  localparam int CTRL_PD_BIT = 0;

  // loop filter and ratio field positions
  localparam int FILT_RES_LO = 2;
  localparam int FILT_CP_LO = 0;
  localparam int RATIO_MULT_LO = 4;
  localparam int RATIO_REF_LO = 2;
  localparam int RATIO_SCALE_LO = 0;

  // source select register and interrupt bits
  localparam int SRC_SEL_BIT = 0;
  localparam int SRC_ACTIVE_BIT = 1;
  localparam int IRQ_SWITCHED_BIT = 0;
  localparam int IRQ_LOCK_LOST_BIT = 1;
  localparam int IRQ_FALLBACK_BIT = 2;
  localparam int IRQ_W = 3;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [1:0] RST_VSEL = 2'h2;
  localparam logic RST_PD = 1'b1;
  localparam logic [1:0] RST_RES = 2'h0;
  localparam logic [1:0] RST_CP = 2'h2;
  localparam logic [3:0] RST_MULT = 4'h1;
  localparam logic [1:0] RST_REF = 2'h0;
  localparam logic [1:0] RST_SCALE = 2'h0;

endpackage

// file: design/scc_clock_control.sv
// system clock control: apb registers, source switch and glitch free divider
// assumes crystal and synthesiser ticks arrive as one-cycle pulses on pclk,
// and the analogue core reports lock as a level synchronous to pclk
//
// The APB register port was decided locally.
`timescale 1ns/1ns

module scc_clock_control
  import scc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock sources
  input wire logic xtal_tick,
  input wire logic synth_tick,
  input wire logic synth_locked,
  // analogue synthesiser controls
  output logic synth_power_down,
  output logic [1:0] test_ctrl_volt_sel,
  output logic [1:0] loop_filter_res_sel,
  output logic [1:0] charge_pump_sel,
  output logic [3:0] feedback_mult_code,
  output logic [1:0] ref_div_code,
  output logic [4:0] synth_mult_m,
  output logic [2:0] synth_div_n,
  // watchdog strobes
  output logic watchdog_clear,
  output logic watchdog_arm,
  // system clock
  output logic sys_clk_en,
  output logic sys_clk_from_synth,
  // interrupt
  output logic irq
);

  // ***********************************************************
  // helpers
  // ***********************************************************
  // address hit for a register index on an aligned word
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    reg_hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == idx);
  endfunction

  // last count value of an output period for a scale code, one less than its ticks
  function automatic logic [2:0] scale_last(input logic [1:0] code);
    case (code)
      2'b00: scale_last = 3'h0;
      2'b01: scale_last = 3'h1;
      2'b10: scale_last = 3'h3;
      default: scale_last = 3'h7;
    endcase
  endfunction

  // ***********************************************************
  // bus decode
  // ***********************************************************
  logic setup_ph;
  logic wr_acc;
  logic hit_ctrl;
  logic hit_filt;
  logic hit_ratio;
  logic hit_src;
  logic hit_stat;
  logic hit_en;
  logic hit_clr;
  logic hit_any;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign hit_ctrl = reg_hit(paddr, IDX_CTRL);
  assign hit_filt = reg_hit(paddr, IDX_FILT);
  assign hit_ratio = reg_hit(paddr, IDX_RATIO);
  assign hit_src = reg_hit(paddr, IDX_SRC);
  assign hit_stat = reg_hit(paddr, IDX_IRQ_STAT);
  assign hit_en = reg_hit(paddr, IDX_IRQ_EN);
  assign hit_clr = reg_hit(paddr, IDX_IRQ_CLR);
  assign hit_any = hit_ctrl | hit_filt | hit_ratio | hit_src | hit_stat | hit_en | hit_clr;

  // zero wait state; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // ***********************************************************
  // software registers
  // ***********************************************************
  logic pd_reg;
  logic [1:0] vsel_reg;
  logic [1:0] res_reg;
  logic [1:0] cp_reg;
  logic [3:0] mult_reg;
  logic [1:0] ref_reg;
  logic [1:0] scale_reg;
  logic src_sel_reg;
  logic [IRQ_W-1:0] irq_en_reg;

  // control register writable fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_reg <= RST_PD;
      vsel_reg <= RST_VSEL;
    end else if (wr_acc && hit_ctrl) begin
      pd_reg <= pwdata[CTRL_PD_BIT];
      vsel_reg <= pwdata[CTRL_VSEL_LO +: 2];
    end
  end

  // loop filter, ratio and divider fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_reg <= RST_RES;
      cp_reg <= RST_CP;
      mult_reg <= RST_MULT;
      ref_reg <= RST_REF;
      scale_reg <= RST_SCALE;
    end else begin
      if (wr_acc && hit_filt) begin
        res_reg <= pwdata[FILT_RES_LO +: 2];
        cp_reg <= pwdata[FILT_CP_LO +: 2];
      end
      if (wr_acc && hit_ratio) begin
        mult_reg <= pwdata[RATIO_MULT_LO +: 4];
        ref_reg <= pwdata[RATIO_REF_LO +: 2];
        scale_reg <= pwdata[RATIO_SCALE_LO +: 2];
      end
    end
  end

  // source select and interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_sel_reg <= 1'b0;
      irq_en_reg <= '0;
    end else begin
      if (wr_acc && hit_src) begin
        src_sel_reg <= pwdata[SRC_SEL_BIT];
      end
      if (wr_acc && hit_en) begin
        irq_en_reg <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // watchdog strobes: one cycle per write of a 1, a 0 does nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_clear <= 1'b0;
      watchdog_arm <= 1'b0;
    end else begin
      watchdog_clear <= wr_acc && hit_ctrl && pwdata[CTRL_WDCLR_BIT];
      watchdog_arm <= wr_acc && hit_ctrl && pwdata[CTRL_WDARM_BIT];
    end
  end

  // ***********************************************************
  // synthesiser status and ratio outputs
  // ***********************************************************
  logic lock_fault;
  // powered down counts as not stable, whatever the core reports
  assign lock_fault = pd_reg || !synth_locked;

  assign synth_power_down = pd_reg;
  assign test_ctrl_volt_sel = vsel_reg;
  assign loop_filter_res_sel = res_reg;
  assign charge_pump_sel = cp_reg;
  assign feedback_mult_code = mult_reg;
  assign ref_div_code = ref_reg;

  // actual ratio terms, registered so the analogue side sees clean levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth_mult_m <= 5'h00;
      synth_div_n <= 3'h0;
    end else begin
      synth_mult_m <= {1'b0, mult_reg} + 5'h01;
      synth_div_n <= {1'b0, ref_reg} + 3'h1;
    end
  end

  // ***********************************************************
  // source switch and divider
  // ***********************************************************
  logic active_src_reg;
  logic [2:0] div_cnt_reg;
  logic [1:0] scale_cur_reg;
  logic src_tick;
  logic at_boundary;
  logic fallback;
  logic switch_up;

  assign src_tick = active_src_reg ? synth_tick : xtal_tick;
  assign at_boundary = src_tick && (div_cnt_reg == scale_last(scale_cur_reg));
  // a failing synthesiser may stop ticking, so fallback cannot wait for a boundary
  assign fallback = active_src_reg && lock_fault;
  assign switch_up = at_boundary && !active_src_reg && src_sel_reg && !lock_fault;

  // scale only changes at the end of a whole output period; source too, except on fallback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_src_reg <= 1'b0;
      scale_cur_reg <= RST_SCALE;
    end else if (fallback) begin
      active_src_reg <= 1'b0;
    end else if (at_boundary) begin
      scale_cur_reg <= scale_reg;
      active_src_reg <= src_sel_reg && !lock_fault;
    end
  end

  // tick counter; restarts on fallback so crystal periods start whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 3'h0;
    end else if (fallback || at_boundary) begin
      div_cnt_reg <= 3'h0;
    end else if (src_tick) begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
    end
  end

  // enable pulse marks each completed output period, except one that ends in a fallback cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= at_boundary && !fallback;
    end
  end

  assign sys_clk_from_synth = active_src_reg;

  // ***********************************************************
  // interrupts
  // ***********************************************************
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_evt;
  logic locked_d_reg;

  // lock loss seen as a falling edge of the healthy state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_d_reg <= 1'b0;
    end else begin
      locked_d_reg <= !lock_fault;
    end
  end

  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_SWITCHED_BIT] = switch_up;
    irq_evt[IRQ_LOCK_LOST_BIT] = locked_d_reg && lock_fault;
    irq_evt[IRQ_FALLBACK_BIT] = fallback;
  end

  // sticky status; an event in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
    end else if (wr_acc && hit_clr) begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_evt;
    end
  end

  assign irq = |(irq_stat_reg & irq_en_reg);

  // ***********************************************************
  // read data, captured in the setup cycle
  // ***********************************************************
  logic [DATA_W-1:0] rd_mux;

  // watchdog strobes and the clear register read as zero
  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) begin
      rd_mux[CTRL_FAULT_BIT] = lock_fault;
      rd_mux[CTRL_VSEL_LO +: 2] = vsel_reg;
      rd_mux[CTRL_PD_BIT] = pd_reg;
    end else if (hit_filt) begin
      rd_mux[FILT_RES_LO +: 2] = res_reg;
      rd_mux[FILT_CP_LO +: 2] = cp_reg;
    end else if (hit_ratio) begin
      rd_mux[RATIO_MULT_LO +: 4] = mult_reg;
      rd_mux[RATIO_REF_LO +: 2] = ref_reg;
      rd_mux[RATIO_SCALE_LO +: 2] = scale_reg;
    end else if (hit_src) begin
      rd_mux[SRC_SEL_BIT] = src_sel_reg;
      rd_mux[SRC_ACTIVE_BIT] = active_src_reg;
    end else if (hit_stat) begin
      rd_mux[IRQ_W-1:0] = irq_stat_reg;
    end else if (hit_en) begin
      rd_mux[IRQ_W-1:0] = irq_en_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_ph && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  sequence wr_ctrl_s;
    wr_acc && hit_ctrl;
  endsequence
  sequence one_pulse_s;
    watchdog_clear ##1 !watchdog_clear;
  endsequence
  chk_stay_on_crystal: assert property (@(posedge pclk) disable iff (!presetn)
    !src_sel_reg && !active_src_reg |=> !active_src_reg)
    else $error("left crystal without selection");
  chk_switch_when_stable: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(active_src_reg) |-> $past(src_sel_reg && !lock_fault && at_boundary))
    else $error("switched to synthesiser while unstable");
  chk_select_written: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && hit_src |=> src_sel_reg == $past(pwdata[SRC_SEL_BIT]))
    else $error("source select not stored");
  chk_scale_boundary: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(scale_cur_reg) |-> sys_clk_en)
    else $error("divider changed mid period");
  chk_source_boundary: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(active_src_reg) |-> sys_clk_en)
    else $error("source changed mid period");
  chk_ratio_terms: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && hit_ratio ##1 1'b1 |=>
      synth_mult_m == {1'b0, $past(pwdata[RATIO_MULT_LO +: 4], 2)} + 5'h01)
    else $error("multiplier term wrong");
  chk_fault_readback: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && !pwrite && hit_ctrl |=> prdata[CTRL_FAULT_BIT] == $past(pd_reg || !synth_locked))
    else $error("fault bit wrong");
  chk_power_down: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl_s |=> synth_power_down == $past(pwdata[CTRL_PD_BIT]))
    else $error("power down not applied");
  chk_wd_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl_s ##0 pwdata[CTRL_WDCLR_BIT] |=> one_pulse_s)
    else $error("watchdog clear pulse wrong");
  chk_wd_arm_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(wr_acc && hit_ctrl && pwdata[CTRL_WDARM_BIT]) |-> !watchdog_arm)
    else $error("watchdog arm without a written one");
  chk_volt_sel: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl_s |=> test_ctrl_volt_sel == $past(pwdata[CTRL_VSEL_LO +: 2]))
    else $error("test voltage select not stored");
endmodule

// file: verif/scc_synth_model.sv
// model of the analogue synthesiser core and the crystal oscillator
// assumes one pclk domain; both sources are seen as one-cycle tick pulses
`timescale 1ns/1ns
module scc_synth_model #(
  parameter int XGAP = 4,
  parameter int SGAP = 2,
  parameter int LOCK = 40
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controls
  input wire logic power_down,
  input wire logic lose_lock,
  // sources
  output logic xtal_tick,
  output logic synth_tick,
  output logic synth_locked
);
  int xc;
  int sc;
  int lc;
  // crystal runs free; synthesiser only oscillates and settles while powered up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xc <= 0;
      sc <= 0;
      lc <= 0;
    end else begin
      xc <= (xc == XGAP - 1) ? 0 : xc + 1;
      sc <= (power_down || sc == SGAP - 1) ? 0 : sc + 1;
      lc <= power_down ? 0 : (lc < LOCK ? lc + 1 : lc);
    end
  end
  assign xtal_tick = presetn && xc == XGAP - 1;
  assign synth_tick = !power_down && sc == SGAP - 1;
  // lock drops at once on power down, never lingers
  assign synth_locked = lc == LOCK && !lose_lock && !power_down;
endmodule

// file: verif/scc_clock_control_bench.sv
// self-checking bench for the system clock control block
// assumes the synthesiser model drives the source ticks and the lock level
`timescale 1ns/1ns
module scc_clock_control_bench import scc_pkg::*;;
  typedef struct packed {logic [7:0] wd; int per;} scc_row_t;
  logic pclk, presetn, psel, penable, pwrite, lose_lock, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic pready, pslverr, xtal_tick, synth_tick, synth_locked, synth_power_down;
  logic [1:0] test_ctrl_volt_sel, loop_filter_res_sel, charge_pump_sel, ref_div_code;
  logic [3:0] feedback_mult_code;
  logic [4:0] synth_mult_m;
  logic [2:0] synth_div_n;
  logic watchdog_clear, watchdog_arm, sys_clk_en, sys_clk_from_synth, irq;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_clr = 0;
  int n_arm = 0;
  int p, k;
  // ratio writes on crystal: one tick every 4 cycles, scale 1,2,4,8
  scc_row_t rows[4] = '{'{8'h10, 4}, '{8'h25, 8}, '{8'h4a, 16}, '{8'hf7, 32}};

  scc_clock_control dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .xtal_tick, .synth_tick, .synth_locked, .synth_power_down,
    .test_ctrl_volt_sel, .loop_filter_res_sel, .charge_pump_sel, .feedback_mult_code,
    .ref_div_code, .synth_mult_m, .synth_div_n, .watchdog_clear, .watchdog_arm,
    .sys_clk_en, .sys_clk_from_synth, .irq);
  scc_synth_model model_u (.pclk, .presetn, .power_down(synth_power_down), .lose_lock,
    .xtal_tick, .synth_tick, .synth_locked);

  // ***********************************************************
  // helpers
  // ***********************************************************
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // strobe counters, plus a ceiling well above the expected run length
  always @(posedge pclk) begin
    cycles++;
    if (watchdog_clear === 1'b1) n_clr++;
    if (watchdog_arm === 1'b1) n_arm++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task wrap_up();
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen at a rising edge
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // cycles from one system clock pulse to the next
  task period(output int q);
    int n;
    n = 0;
    while (sys_clk_en !== 1'b1 && n < 100) begin
      @(posedge pclk);
      #1 n++;
    end
    q = 0;
    do begin
      @(posedge pclk);
      #1 q++;
    end while (sys_clk_en !== 1'b1 && q < 100);
  endtask

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    {psel, penable, pwrite, lose_lock, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IDX_CTRL, '0);
    chk(rd, 32'h0000_00c1);
    chk({31'b0, synth_power_down}, 32'h0000_0001);
    apb(1'b0, IDX_FILT, '0);
    chk(rd, 32'h0000_0002);
    chk({31'b0, sys_clk_from_synth}, '0);
    // table of ratio settings: period, read back and derived m and n
    foreach (rows[i]) begin
      apb(1'b1, IDX_RATIO, {24'b0, rows[i].wd});
      period(p);
      period(p);
      chk(p, rows[i].per);
      apb(1'b0, IDX_RATIO, '0);
      chk(rd, {24'b0, rows[i].wd});
      chk({27'b0, synth_mult_m}, 32'(rows[i].wd[7:4]) + 1);
      chk({29'b0, synth_div_n}, 32'(rows[i].wd[3:2]) + 1);
      chk({26'b0, feedback_mult_code, ref_div_code}, 32'(rows[i].wd[7:2]));
    end
    apb(1'b1, IDX_FILT, 32'h0000_000f);
    // written fields only settle after the commit edge, so look a step later
    #1 chk({28'b0, loop_filter_res_sel, charge_pump_sel}, 32'h0000_000f);
    // watchdog strobes: clear alone, then zeros, then arm alone, so a swap shows
    apb(1'b1, IDX_CTRL, 32'h0000_0005);
    apb(1'b1, IDX_CTRL, 32'h0000_0061);
    #1 chk(n_clr, 1);
    chk(n_arm, 0);
    chk({30'b0, test_ctrl_volt_sel}, 32'h0000_0003);
    apb(1'b1, IDX_CTRL, 32'h0000_0063);
    apb(1'b0, IDX_CTRL, '0);
    chk(rd, 32'h0000_00e1);
    chk(n_arm, 1);
    chk(n_clr, 1);
    // selecting the synthesiser while it is powered down must not switch
    apb(1'b1, IDX_IRQ_EN, 32'h0000_0007);
    apb(1'b1, IDX_SRC, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    #1 chk({31'b0, sys_clk_from_synth}, '0);
    apb(1'b0, IDX_SRC, '0);
    chk(rd, 32'h0000_0001);
    // ratio 3/1 keeps the oscillator inside its range, then power up
    apb(1'b1, IDX_RATIO, 32'h0000_0020);
    apb(1'b1, IDX_CTRL, 32'h0000_0060);
    k = 0;
    while (sys_clk_from_synth !== 1'b1 && k < 200) begin
      @(posedge pclk);
      #1 k++;
    end
    chk({31'b0, sys_clk_from_synth}, 32'h0000_0001);
    apb(1'b0, IDX_SRC, '0);
    chk(rd, 32'h0000_0003);
    apb(1'b0, IDX_CTRL, '0);
    chk(rd, 32'h0000_0060);
    period(p);
    period(p);
    chk(p, 2);
    chk({31'b0, irq}, 32'h0000_0001);
    apb(1'b0, IDX_IRQ_STAT, '0);
    chk(rd, 32'h0000_0001);
    apb(1'b1, IDX_IRQ_CLR, 32'h0000_0001);
    #1 chk({31'b0, irq}, '0);
    // lock lost while running on the synthesiser
    @(posedge pclk);
    lose_lock <= 1'b1;
    repeat (3) @(posedge pclk);
    #1 chk({31'b0, sys_clk_from_synth}, '0);
    apb(1'b0, IDX_CTRL, '0);
    chk(rd, 32'h0000_00e0);
    apb(1'b0, IDX_IRQ_STAT, '0);
    chk(rd, 32'h0000_0006);
    lose_lock <= 1'b0;
    // unmapped address is refused and reads zero
    apb(1'b0, 16'h0000, '0);
    chk({31'b0, err}, 32'h0000_0001);
    chk(rd, '0);
    // second reset in mid-run returns to crystal and reset values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1 chk({31'b0, sys_clk_from_synth}, '0);
    apb(1'b0, IDX_CTRL, '0);
    chk(rd, 32'h0000_00c1);
    wrap_up();
  end
endmodule
